// [logic/burst_mem.sv]
// Purpose: storage array with bit-masked write and registered read
// Assumes: single clock, read of a location written in the same cycle
//   returns the old contents
// Notes: array itself has no reset, like the cells it models
`include "sram_cmd_map.svh"

module burst_mem (
  input wire logic mclk,
  input wire logic rst_n,
  sram_mem_if.mem port
);

  logic [`DATA_W-1:0] store [`MEM_DEPTH];
  logic [`DATA_W-1:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      // unselected lanes keep their stored bits
      store[port.waddr] <= (store[port.waddr] & ~port.wbe) |
                           (port.wdata & port.wbe);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= store[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule : burst_mem

// [logic/sram_cmd_ctrl.sv]
// Purpose: command decode, burst-of-two sequencing and lane write masking
// Assumes: pins sampled by mclk, each input clock half period >= 2 mclk
// Notes: clock pins are sampled levels; no edge means no state change
//
// Overview of operation
// - write starts on K rise with write select low; words on K, then K#
// - write address is captured on the K# rise, not the K rise
// - read starting in t drives word 0 at C# t+1, word 1 at C t+2
// - read and write starts are independent and may share a cycle
// - first word goes to the base address, second to base plus one
// - after power-up the read outputs stay off until a read
// - writes use both input clocks; reads use output pair or input pair
// - lane selects sampled per data word, K for first, K# for second
// - 8-bit width: select 0 writes bits 3:0, select 1 bits 7:4
// - 18-bit width: select 0 writes bits 8:0, select 1 bits 17:9
// - 8 and 18-bit widths: both selects high write nothing
// - 9-bit width: one select governs bits 8:0
// - 36-bit width: four selects each govern one 9-bit lane
// - 36-bit width: all selects high leave the word unchanged
// - 36-bit width: all selects low write bits 35:0
// - deselected read port goes off after the next output clock rise
// - PLL strap low gives read latency of one cycle
// - output clocks both high at power-on select single clock mode
//
// Implementation choices: the register offsets and register access over APB.
`include "sram_cmd_map.svh"

module sram_cmd_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic cClk,
  input wire logic cClkN,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [3:0] lane_write_select_n,
  input wire logic [1:0] half_lane_write_select_n,
  input wire logic pll_disable_strap,
  input wire logic [`ADDR_W-1:0] addrIn,
  input wire logic [`DATA_W-1:0] dataIn,
  output logic [`DATA_W-1:0] dataOut,
  output logic dataOutOe
);

  // per-bit write enable for one data word
  function automatic logic [`DATA_W-1:0] laneBits(
    input sram_cmd_pkg::width_mode_t mode,
    input logic [3:0] sel_n,
    input logic [1:0] half_n);
    logic [`DATA_W-1:0] bits;
    bits = '0;
    case (mode)
      sram_cmd_pkg::WIDTH8: begin
        bits[3:0] = {4{~half_n[0]}};
        bits[7:4] = {4{~half_n[1]}};
      end
      sram_cmd_pkg::WIDTH9: begin
        bits[8:0] = {`LANE_W{~sel_n[0]}};
      end
      sram_cmd_pkg::WIDTH18: begin
        bits[17:0] = {{`LANE_W{~sel_n[1]}}, {`LANE_W{~sel_n[0]}}};
      end
      sram_cmd_pkg::WIDTH36: begin
        for (int i = 0; i < 4; i++) begin
          bits[i*`LANE_W +: `LANE_W] = {`LANE_W{~sel_n[i]}};
        end
      end
      default: bits = '0;
    endcase
    return bits;
  endfunction : laneBits

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // pin synchroniser: every pin passes two flops
  logic [`SYNC_W-1:0] syncMeta_q;
  logic [`SYNC_W-1:0] sync_q;
  logic kS, kNS, cS, cNS, rpsS, wpsS, strapS;
  logic [3:0] laneS;
  logic [1:0] halfS;
  logic [`ADDR_W-1:0] addrS;
  logic [`DATA_W-1:0] dataS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_q <= `SYNC_RST;
      sync_q <= `SYNC_RST;
    end else begin
      syncMeta_q <= {kClk, kClkN, cClk, cClkN, read_port_select_n,
                     write_port_select_n, lane_write_select_n,
                     half_lane_write_select_n, pll_disable_strap,
                     addrIn, dataIn};
      sync_q <= syncMeta_q;
    end
  end

  assign {kS, kNS, cS, cNS, rpsS, wpsS, laneS, halfS, strapS, addrS,
          dataS} = sync_q;

  // no edges until the pin history has filled, so reset makes none
  logic strapDone_q;
  logic [3:0] clkPrev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_q <= 4'h0;
    end else begin
      clkPrev_q <= {kS, kNS, cS, cNS};
    end
  end

  wire kRise = strapDone_q & kS & ~clkPrev_q[3];
  wire kNRise = strapDone_q & kNS & ~clkPrev_q[2];
  wire cRise = strapDone_q & cS & ~clkPrev_q[1];
  wire cNRise = strapDone_q & cNS & ~clkPrev_q[0];

  // strap caught once the synchroniser has filled after reset
  logic [1:0] strapCnt_q;
  logic singleClock_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      singleClock_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == `STRAP_WAIT) begin
        strapDone_q <= 1'b1;
        singleClock_q <= cS & cNS;
      end
    end
  end

  wire pllOff = ~strapS;
  wire outEdge = singleClock_q ? (kRise | kNRise) : (cRise | cNRise);

  // control register: width mode steers lane masking
  sram_cmd_pkg::width_mode_t widthMode_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  wire apbAccess = psel & penable;
  wire hitCtrl = (paddr == `CTRL_OFS);
  wire hitStatus = (paddr == `STATUS_OFS);
  wire ctrlWrite = apbAccess & pready_q & pwrite & hitCtrl;

  // write path
  logic wrArmed_q, wrSecond_q;
  logic [`DATA_W-1:0] wrData0_q, wrData1_q, wrMask0_q, wrMask1_q;
  logic [`ADDR_W-1:0] wrBase_q;

  wire [`DATA_W-1:0] laneNow = laneBits(widthMode_q, laneS, halfS);
  wire wrStart = kRise & ~wpsS;
  wire wrFirst = wrArmed_q & kNRise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrArmed_q <= 1'b0;
    end else if (kRise) begin
      wrArmed_q <= ~wpsS;
    end else if (kNRise) begin
      wrArmed_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrData0_q <= '0;
      wrMask0_q <= '0;
    end else if (wrStart) begin
      wrData0_q <= dataS;
      wrMask0_q <= laneNow;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrSecond_q <= 1'b0;
      wrBase_q <= '0;
      wrData1_q <= '0;
      wrMask1_q <= '0;
    end else begin
      wrSecond_q <= wrFirst;
      if (wrFirst) begin
        wrBase_q <= addrS;
        wrData1_q <= dataS;
        wrMask1_q <= laneNow;
      end
    end
  end

  sram_mem_if memBus ();

  // word 0 goes in on the K# rise, word 1 one mclk later
  assign memBus.we = wrFirst | wrSecond_q;
  assign memBus.waddr = wrSecond_q ? wrBase_q + 1'b1 : addrS;
  assign memBus.wdata = wrSecond_q ? wrData1_q : wrData0_q;
  assign memBus.wbe = wrSecond_q ? wrMask1_q : wrMask0_q;

  // read path: slot i leaves on the (i+1)th next output edge
  sram_cmd_pkg::slot_t slot_q [`SLOTS];
  sram_cmd_pkg::slot_t slot_d [`SLOTS];
  wire rdStart = kRise & ~rpsS;
  wire [1:0] firstIdx = pllOff ? 2'(`FIRST_EDGE_NOPLL - 1) :
                                 2'(`FIRST_EDGE_PLL - 1);

  always_comb begin
    for (int i = 0; i < `SLOTS; i++) begin
      if (!outEdge) begin
        slot_d[i] = slot_q[i];
      end else if (i < `SLOTS - 1) begin
        slot_d[i] = slot_q[i+1];
      end else begin
        slot_d[i] = '0;
      end
    end
    if (rdStart) begin
      slot_d[firstIdx] = '{valid: 1'b1, addr: addrS};
      slot_d[firstIdx + 2'h1] = '{valid: 1'b1, addr: addrS + 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SLOTS; i++) begin
        slot_q[i] <= '0;
      end
    end else begin
      slot_q <= slot_d;
    end
  end

  // array read runs one mclk ahead of the edge that drives it out
  assign memBus.raddr = slot_q[0].addr;

  burst_mem array (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(memBus.mem)
  );

  logic [`DATA_W-1:0] dataOut_q;
  logic dataOutOe_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_q <= '0;
      dataOutOe_q <= 1'b0;
    end else if (outEdge) begin
      dataOutOe_q <= slot_q[0].valid;
      if (slot_q[0].valid) begin
        dataOut_q <= memBus.rdata;
      end
    end
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      widthMode_q <= sram_cmd_pkg::width_mode_t'(`CTRL_RST);
    end else if (ctrlWrite) begin
      widthMode_q <= sram_cmd_pkg::width_mode_t'(pwdata[`CTRL_WIDTH_LSB +: 2]);
    end
  end

  wire [31:0] statusWord = {27'h0, strapDone_q, wrArmed_q | wrSecond_q,
                            dataOutOe_q, pllOff, singleClock_q};
  wire [31:0] readMux = hitCtrl ? {30'h0, widthMode_q} :
                        (hitStatus ? statusWord : 32'h0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apbAccess & ~pready_q;
      if (apbAccess & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0 : readMux;
        pslverr_q <= ~(hitCtrl | (hitStatus & ~pwrite));
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dataOut = dataOut_q;
  assign dataOutOe = dataOutOe_q;

  // helper: has any read ever been started
  logic everRead_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      everRead_q <= 1'b0;
    end else if (rdStart) begin
      everRead_q <= 1'b1;
    end
  end

  property p_write_arm;
    wrStart |=> wrArmed_q && wrData0_q == $past(dataS);
  endproperty
  a_write_arm: assert property (p_write_arm)
    else $error("write start not armed");

  property p_write_addr;
    wrFirst |=> wrSecond_q && wrBase_q == $past(addrS);
  endproperty
  a_write_addr: assert property (p_write_addr)
    else $error("write address not taken on K# rise");

  property p_burst_next;
    wrFirst ##1 wrSecond_q |-> memBus.we && memBus.waddr == $past(addrS) + 1'b1;
  endproperty
  a_burst_next: assert property (p_burst_next)
    else $error("second word not at base plus one");

  property p_concurrent;
    kRise && !rpsS && !wpsS |=> wrArmed_q && slot_q[firstIdx].valid;
  endproperty
  a_concurrent: assert property (p_concurrent)
    else $error("read and write did not both start");

  property p_read_pll;
    rdStart && !pllOff |=> slot_q[2].valid && slot_q[3].valid;
  endproperty
  a_read_pll: assert property (p_read_pll)
    else $error("read slots wrong for 1.5 cycle latency");

  property p_read_nopll;
    rdStart && pllOff |=> slot_q[1].valid && slot_q[2].valid;
  endproperty
  a_read_nopll: assert property (p_read_nopll)
    else $error("read slots wrong for 1 cycle latency");

  property p_release;
    outEdge && !slot_q[0].valid |=> !dataOutOe;
  endproperty
  a_release: assert property (p_release)
    else $error("read outputs not released");

  property p_powerup;
    !everRead_q |-> !dataOutOe;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("outputs driven before any read");

  property p_nop;
    kRise && rpsS && wpsS |=> !wrArmed_q && !wrSecond_q;
  endproperty
  a_nop: assert property (p_nop)
    else $error("operation started on nop");

  property p_mask_none;
    wrStart && widthMode_q == sram_cmd_pkg::WIDTH36 && (&laneS)
      |=> wrMask0_q == '0;
  endproperty
  a_mask_none: assert property (p_mask_none)
    else $error("masked word would be written");

  property p_hold;
    !(kRise || kNRise || outEdge || wrSecond_q)
      |=> $stable(dataOut) && $stable(dataOutOe) && $stable(wrArmed_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved without a clock edge");

endmodule : sram_cmd_ctrl

// [pkg/sram_cmd_map.svh]
// Purpose: offsets, field positions, reset values and counts
// Assumes: 36-bit data path, 64-word array, APB with 12-bit address
// Notes: definitions only
`ifndef SRAM_CMD_MAP_SVH
`define SRAM_CMD_MAP_SVH

`define DATA_W 36
`define ADDR_W 6
`define MEM_DEPTH 64
`define LANE_W 9
`define PADDR_W 12
`define SYNC_W 55
// select pins idle high in the synchroniser so reset looks like a nop
`define SYNC_RST 55'h7F8_0000000000
`define SLOTS 4
`define FIRST_EDGE_PLL 3
`define FIRST_EDGE_NOPLL 2
`define STRAP_WAIT 2'h3

`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define CTRL_WIDTH_LSB 0
`define CTRL_RST 2'h3
`define ST_SINGLE 0
`define ST_PLLOFF 1
`define ST_RDOE 2
`define ST_WRBUSY 3
`define ST_STRAPPED 4

`endif

// [pkg/sram_cmd_pkg.sv]
// Purpose: types shared by the controller and the bench
// Assumes: sram_cmd_map.svh supplies the widths
// Notes: width mode codes follow the CTRL width field order
`include "sram_cmd_map.svh"

package sram_cmd_pkg;

  typedef enum logic [1:0] {WIDTH8, WIDTH9, WIDTH18, WIDTH36} width_mode_t;

  typedef struct packed {
    logic valid;
    logic [`ADDR_W-1:0] addr;
  } slot_t;

endpackage : sram_cmd_pkg

// [pkg/sram_mem_if.sv]
// Purpose: carrier between the controller and the burst array
// Assumes: one write and one read port per clock
// Notes: wbe is a per-bit write enable
`include "sram_cmd_map.svh"

interface sram_mem_if;
  logic we;
  logic [`ADDR_W-1:0] waddr;
  logic [`DATA_W-1:0] wdata;
  logic [`DATA_W-1:0] wbe;
  logic [`ADDR_W-1:0] raddr;
  logic [`DATA_W-1:0] rdata;

  modport ctrl (output we, waddr, wdata, wbe, raddr, input rdata);
  modport mem (input we, waddr, wdata, wbe, raddr, output rdata);
endinterface : sram_mem_if

// [tb/sram_host_model.sv]
// Purpose: host controller model making clocks, selects and data
// Assumes: 4 mclk per clock half, above the 2-flop pin sampling
// Notes: keeps one capture of the read pins per half for the bench
`include "sram_cmd_map.svh"

module sram_host_model (
  input wire logic mclk,
  input wire logic [`DATA_W-1:0] dataOut,
  input wire logic dataOutOe,
  output logic kClk,
  output logic kClkN,
  output logic cClk,
  output logic cClkN,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [3:0] lane_write_select_n,
  output logic [1:0] half_lane_write_select_n,
  output logic pll_disable_strap,
  output logic [`ADDR_W-1:0] addrIn,
  output logic [`DATA_W-1:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`DATA_W:0] cap[$];
  logic single = 1'b0;

  // stopped mid-cycle, C and C# apart so single clock mode is not strapped
  initial begin
    {kClk, kClkN, cClk, cClkN} = 4'h5;
    {read_port_select_n, write_port_select_n} = 2'h3;
    lane_write_select_n = 4'hF;
    half_lane_write_select_n = 2'h3;
    pll_disable_strap = 1'b1;
    addrIn = '0;
    dataIn = '0;
  end

  task automatic half(input logic ph, rs, ws,
      input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d,
      input logic [3:0] m);
    @(posedge mclk);
    kClk <= ph;
    kClkN <= !ph;
    cClk <= ph | single;
    cClkN <= !ph | single;
    read_port_select_n <= rs;
    write_port_select_n <= ws;
    addrIn <= a;
    dataIn <= d;
    lane_write_select_n <= m;
    half_lane_write_select_n <= m[1:0];
    @(negedge mclk);
    @(negedge mclk);
    cap.push_back({dataOutOe, dataOut});
    repeat (2) @(posedge mclk);
  endtask : half

  task automatic cyc(input logic rs, ws, input logic [`ADDR_W-1:0] ra, wa,
      input logic [`DATA_W-1:0] d0, d1, input logic [3:0] m0, m1);
    half(1'b1, rs, ws, ra, d0, m0);
    half(1'b0, 1'b1, 1'b1, wa, d1, m1);
  endtask : cyc

  // single clock strap: C and C# held high from now on
  task automatic strapSingle;
    @(posedge mclk);
    single <= 1'b1;
    cClk <= 1'b1;
    cClkN <= 1'b1;
  endtask : strapSingle
endmodule : sram_host_model

// [tb/test_dual_port_burst2_sram_cmd_bytewrite.sv]
// Purpose: self-checking bench for the burst SRAM command block
// Assumes: host model makes the clock pairs, 4 mclk per half
// Notes: narrow widths are judged on their own data bits only
`include "sram_cmd_map.svh"

module test_dual_port_burst2_sram_cmd_bytewrite;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic kClk, kClkN, cClk, cClkN, pll_disable_strap, dataOutOe;
  logic read_port_select_n, write_port_select_n;
  logic [3:0] lane_write_select_n;
  logic [1:0] half_lane_write_select_n;
  logic [`ADDR_W-1:0] addrIn;
  logic [`DATA_W-1:0] dataIn, dataOut;
  logic [`DATA_W-1:0] mem [`MEM_DEPTH];
  sram_cmd_pkg::width_mode_t mode = sram_cmd_pkg::WIDTH36;
  int miscompares = 0;
  int checked = 0;

  always #50 mclk = ~mclk;

  sram_cmd_ctrl uut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .kClk, .kClkN, .cClk, .cClkN,
    .read_port_select_n, .write_port_select_n, .lane_write_select_n,
    .half_lane_write_select_n, .pll_disable_strap, .addrIn, .dataIn,
    .dataOut, .dataOutOe);

  sram_host_model host (.mclk, .dataOut, .dataOutOe, .kClk, .kClkN, .cClk,
    .cClkN, .read_port_select_n, .write_port_select_n, .lane_write_select_n,
    .half_lane_write_select_n, .pll_disable_strap, .addrIn, .dataIn);

  task automatic chkData(input logic [`DATA_W-1:0] got, exp, msk);
    checked++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask : chkData

  task automatic chkBit(input logic got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkBit

  task automatic apb(input logic wr, input logic [`PADDR_W-1:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chkBit(n < 20, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // lanes are 4 bits wide in 8-bit mode, 9 bits otherwise
  function automatic logic [`DATA_W-1:0] merge(input logic [3:0] m,
      input logic [`DATA_W-1:0] old, d);
    int lw;
    int nl;
    lw = (mode == sram_cmd_pkg::WIDTH8) ? 4 : `LANE_W;
    nl = (mode == sram_cmd_pkg::WIDTH9) ? 1 :
         (mode == sram_cmd_pkg::WIDTH36) ? 4 : 2;
    merge = old;
    for (int b = 0; b < `DATA_W; b++)
      if (b / lw < nl && !m[b / lw]) merge[b] = d[b];
  endfunction : merge

  task automatic go(input logic rs, ws, input logic [`ADDR_W-1:0] ra, wa,
      input logic [`DATA_W-1:0] d0, d1, input logic [3:0] m0, m1);
    host.cyc(rs, ws, ra, wa, d0, d1, m0, m1);
    if (!ws) begin
      mem[wa] = merge(m0, mem[wa], d0);
      mem[wa + 1'b1] = merge(m1, mem[wa + 1'b1], d1);
    end
  endtask : go

  // reads a, then b with an optional write in the same cycle
  task automatic readTwo(input logic [`ADDR_W-1:0] a, b, input logic ws,
      input logic [`ADDR_W-1:0] wa, input logic [`DATA_W-1:0] d,
      input int w0);
    logic [`DATA_W-1:0] exp [4];
    logic [`DATA_W-1:0] msk;
    exp = '{mem[a], mem[a + 1'b1], mem[b], mem[b + 1'b1]};
    msk = (mode == sram_cmd_pkg::WIDTH8) ? 36'h0_0000_00FF :
          (mode == sram_cmd_pkg::WIDTH9) ? 36'h0_0000_01FF :
          (mode == sram_cmd_pkg::WIDTH18) ? 36'h0_0003_FFFF : '1;
    host.cap.delete();
    go(1'b0, 1'b1, a, ~a, '0, '0, 4'hF, 4'hF);
    go(1'b0, ws, b, wa, d, d, 4'h0, 4'h0);
    repeat (3) go(1'b1, 1'b1, ~b, ~b, '1, '0, 4'h0, 4'h0);
    chkBit(host.cap[w0 - 1][`DATA_W], 1'b0);
    for (int i = 0; i < 4; i++) begin
      chkBit(host.cap[w0 + i][`DATA_W], 1'b1);
      chkData(host.cap[w0 + i][`DATA_W-1:0], exp[i], msk);
    end
    chkBit(host.cap[w0 + 4][`DATA_W], 1'b0);
  endtask : readTwo

  task automatic resetState;
    chkBit(dataOutOe, 1'b0);
    apb(1'b0, `CTRL_OFS, '0);
    chkData({4'h0, rd}, 36'(`CTRL_RST), 36'h3);
    apb(1'b0, `STATUS_OFS, '0);
    chkData({4'h0, rd}, 36'h10, 36'h17);
    apb(1'b1, `STATUS_OFS, '0);
    chkBit(err, 1'b1);
    apb(1'b0, 12'h008, '0);
    chkData({4'h0, rd}, '0, '1);
    chkBit(err, 1'b1);
  endtask : resetState

  task automatic fullBursts;
    go(1'b1, 1'b0, 6'h01, 6'h3E, 36'hA_5A5A_5A5A, 36'h1_2345_6789, 4'h0, 4'h0);
    go(1'b1, 1'b0, 6'h02, 6'h3F, 36'h9_8765_4321, 36'hC_3C3C_3C3C, 4'h0, 4'h0);
    readTwo(6'h3E, 6'h3F, 1'b1, 6'h00, '0, 4);
  endtask : fullBursts

  task automatic laneMasks;
    go(1'b1, 1'b0, 6'h00, 6'h0A, '1, '0, 4'h0, 4'h0);
    go(1'b1, 1'b0, 6'h00, 6'h0A, 36'h1_2345_6789, '1, 4'hA, 4'hF);
    go(1'b1, 1'b0, 6'h00, 6'h0C, '0, '0, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++)
      go(1'b1, 1'b0, 6'h0, 6'h0C, {4{9'(3 * i + 1)}}, '1, ~(4'h1 << i), 4'hF);
    go(1'b1, 1'b1, 6'h0A, 6'h0A, '0, '0, 4'h0, 4'h0);
    @(negedge mclk);
    chkBit(dataOutOe, 1'b0);
    readTwo(6'h0A, 6'h0C, 1'b0, 6'h30, 36'h5_5555_5555, 4);
  endtask : laneMasks

  task automatic narrowWidths;
    logic [`ADDR_W-1:0] a;
    for (int k = 0; k < 3; k++) begin
      mode = sram_cmd_pkg::width_mode_t'(k);
      a = 6'h14 + 6'(2 * k);
      apb(1'b1, `CTRL_OFS, 32'(k));
      go(1'b1, 1'b0, ~a, a, '0, '1, 4'h0, 4'h0);
      go(1'b1, 1'b0, ~a, a, 36'h9_A5C3_7E1B, '0, 4'hE, 4'hD);
      go(1'b1, 1'b0, ~a, a, '1, 36'h5_A5A5_A5A5, 4'hF, 4'hF);
      readTwo(a, a, 1'b1, a, '0, 4);
    end
    mode = sram_cmd_pkg::WIDTH36;
    apb(1'b1, `CTRL_OFS, 32'h0000_0003);
  endtask : narrowWidths

  task automatic shortLatency;
    @(posedge mclk);
    host.pll_disable_strap <= 1'b0;
    apb(1'b0, `STATUS_OFS, '0);
    chkData({4'h0, rd}, 36'h2, 36'h2);
    readTwo(6'h3E, 6'h0A, 1'b1, 6'h00, '0, 3);
  endtask : shortLatency

  // second reset with C and C# tied high selects single clock mode
  task automatic singleClock;
    host.strapSingle();
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chkBit(dataOutOe, 1'b0);
    apb(1'b0, `STATUS_OFS, '0);
    chkData({4'h0, rd}, 36'h13, 36'h17);
    readTwo(6'h0C, 6'h3E, 1'b0, 6'h20, 36'h3_0303_0303, 3);
  endtask : singleClock

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (3000) @(posedge mclk);
    $display("ERROR %0t watchdog expired", $time);
    miscompares++;
    results();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    resetState();
    fullBursts();
    laneMasks();
    narrowWidths();
    shortLatency();
    singleClock();
    results();
  end
endmodule : test_dual_port_burst2_sram_cmd_bytewrite
